// file: hdl/ccpmd_top.sv
/*
 * one capture/compare/pwm module timed by the shared main counter.
 * holds its configuration, compare/capture and interrupt registers,
 * decodes the mode and drives or samples module_pin.
 * assumes main_count_i comes from logic on sys_clk_i and that the
 * register master keeps strobes one cycle long and never both at once.
 */
// Our own choices: the register offsets and the address-and-strobe port.
module ccpmd_top (
	input  wire logic                           sys_clk_i,
	input  wire logic                           rst_i,
	input  wire logic [ccpmd_pkg::ADDR_W-1:0]   addr_i,
	input  wire logic [ccpmd_pkg::DATA_W-1:0]   wdata_i,
	input  wire logic                           wr_i,
	input  wire logic                           rd_i,
	output logic      [ccpmd_pkg::DATA_W-1:0]   rdata_o,
	input  wire logic [ccpmd_pkg::CNT_W-1:0]    main_count_i,
	input  wire logic                           module_pin_i,
	output logic                                module_pin_o,
	output logic                                module_pin_oe_n_o,
	output logic                                irq_o
);
	import ccpmd_pkg::*;

	// every flip-flop of the module
	typedef struct packed {
		logic [DATA_W-1:0] cfg;
		logic [DATA_W-1:0] cmp_l;
		logic [DATA_W-1:0] cmp_h;
		logic [CNT_W-1:0]  act;     // active comparator value
		logic [CNT_W-1:0]  cnt_d;   // counter one cycle ago
		logic [ST_W-1:0]   status;
		logic [ST_W-1:0]   mask;
		logic [DATA_W-1:0] rdata;
		logic              pin;
		logic              oe_n;
		logic              irq;
	} ccpmd_state_t;

	ccpmd_state_t r;
	ccpmd_state_t next_r;

	// pin synchroniser and edge detector
	ccpmd_edge_if edges ();

	ccpmd_pin_sync u_sync (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.pin_i     (module_pin_i),
		.edge_o    (edges)
	);

	// mode decode from the configuration byte
	function automatic ccpmd_mode_t mode_of(input logic [DATA_W-1:0] c);
		ccpmd_mode_t m;
		m = MODE_IDLE;
		if (!c[CFG_COMPARATOR_ENABLE]) begin
			m = MODE_IDLE;
		end else if (c[CFG_PWM]) begin
			if (c[CFG_RISE] && c[CFG_FALL]) begin
				m = MODE_WINDOWED_PULSE_MODE;
			end else if (c[CFG_RISE]) begin
				m = MODE_PWM16;
			end else if (!c[CFG_FALL]) begin
				m = MODE_PWM8;
			end
		end else if (c[CFG_RISE] || c[CFG_FALL]) begin
			m = MODE_CAPTURE;
		end else begin
			m = MODE_COMPARE;
		end
		return m;
	endfunction

	// decoded mode and qualified strobes
	ccpmd_mode_t       mode;
	logic              wr_cfg;
	logic              wr_l;
	logic              wr_h;
	logic              wr_st;
	logic              wr_mask;
	logic              cnt_ovf;
	logic              cl_ovf;
	logic [DATA_W-1:0] cl;
	logic [DATA_W-1:0] act_l;
	logic [DATA_W-1:0] act_h;
	logic              cap_hit;
	logic              match16;
	logic              ev_ccf;
	logic              pwm_out;
	logic              hw_set_ok;

	assign mode    = mode_of(r.cfg);
	assign wr_cfg  = wr_i && (addr_i == ADDR_CFG);
	assign wr_l    = wr_i && (addr_i == ADDR_CMP_L);
	assign wr_h    = wr_i && (addr_i == ADDR_CMP_H);
	assign wr_st   = wr_i && (addr_i == ADDR_STATUS);
	assign wr_mask = wr_i && (addr_i == ADDR_MASK);

	// counter wrap detection from the previous sample
	assign cnt_ovf = (r.cnt_d == CNT_MAX) && (main_count_i == RST_CNT);
	assign cl      = main_count_i[DATA_W-1:0];
	assign cl_ovf  = (r.cnt_d[DATA_W-1:0] == BYTE_MAX) && (cl == RST_REG);
	assign act_l   = r.act[DATA_W-1:0];
	assign act_h   = r.act[CNT_W-1:DATA_W];
	assign match16 = (main_count_i == r.act);

	// capture edge as chosen by the edge selects
	assign cap_hit = (mode == MODE_CAPTURE) &&
		((r.cfg[CFG_RISE] && edges.rise) ||
		 (r.cfg[CFG_FALL] && edges.fall));

	// hardware may set the enable only from a compare setup
	assign hw_set_ok = !r.cfg[CFG_RISE] && !r.cfg[CFG_FALL] && !r.cfg[CFG_PWM] &&
		(r.cfg[CFG_OF] || r.cfg[CFG_MAT] || r.cfg[CFG_TOG]);

	// pwm level and event of the current mode
	always_comb begin
		pwm_out = r.pin;
		ev_ccf  = 1'b0;
		case (mode)
			MODE_CAPTURE: begin
				ev_ccf = cap_hit;
			end
			MODE_COMPARE: begin
				ev_ccf = match16 && r.cfg[CFG_MAT];
			end
			MODE_PWM8: begin
				pwm_out = (cl > act_l);
				ev_ccf  = (cl == act_l);
			end
			MODE_PWM16: begin
				pwm_out = (main_count_i > r.act);
				ev_ccf  = match16;
			end
			MODE_WINDOWED_PULSE_MODE: begin
				pwm_out = (cl > act_l) && !(cl > act_h);
				ev_ccf  = (cl == act_l) || (r.cfg[CFG_MAT] && (cl == act_h));
			end
			default: begin
				pwm_out = r.pin;
				ev_ccf  = 1'b0;
			end
		endcase
	end

	// next state of all registers
	always_comb begin
		next_r       = r;
		next_r.cnt_d = main_count_i;

		// configuration written by software
		if (wr_cfg) begin
			next_r.cfg = wdata_i;
		end

		// compare registers and the hardware enable control
		if (wr_l) begin
			next_r.cmp_l = wdata_i;
			if (mode == MODE_COMPARE) begin
				next_r.cfg[CFG_COMPARATOR_ENABLE] = 1'b0;
			end
		end
		if (wr_h) begin
			next_r.cmp_h = wdata_i;
			if (hw_set_ok) begin
				next_r.cfg[CFG_COMPARATOR_ENABLE] = 1'b1;
			end
		end

		// capture wins over a software write in the same cycle
		if (cap_hit) begin
			next_r.cmp_l = cl;
			next_r.cmp_h = main_count_i[CNT_W-1:DATA_W];
		end

		// buffered compare value moves to the comparator on wrap, and every cycle while idle or capturing
		case (mode)
			MODE_COMPARE, MODE_PWM16: begin
				if (cnt_ovf) begin
					next_r.act = {r.cmp_h, r.cmp_l};
				end
			end
			MODE_PWM8, MODE_WINDOWED_PULSE_MODE: begin
				if (cl_ovf) begin
					next_r.act = {r.cmp_h, r.cmp_l};
				end
			end
			default: begin
				next_r.act = {r.cmp_h, r.cmp_l};
			end
		endcase

		// pin drive per mode
		case (mode)
			MODE_COMPARE: begin
				next_r.oe_n = 1'b0;
				if (match16) begin
					case ({r.cfg[CFG_OF], r.cfg[CFG_TOG]})
						2'b01:   next_r.pin = ~r.pin;
						2'b10:   next_r.pin = 1'b0;
						2'b11:   next_r.pin = 1'b1;
						default: next_r.pin = r.pin;
					endcase
				end
			end
			MODE_PWM8, MODE_PWM16: begin
				next_r.oe_n = 1'b0;
				next_r.pin  = r.cfg[CFG_TOG] ? 1'b1 : pwm_out;
			end
			MODE_WINDOWED_PULSE_MODE: begin
				next_r.oe_n = 1'b0;
				next_r.pin  = r.cfg[CFG_TOG] ? ~pwm_out : pwm_out;
			end
			MODE_CAPTURE: begin
				next_r.oe_n = 1'b1; // pin is an input
				next_r.pin  = edges.level;
			end
			default: begin
				next_r.oe_n = 1'b1; // idle: matches are ignored
				next_r.pin  = r.pin;
			end
		endcase

		// sticky status: write one clears, a new event wins
		if (wr_st) begin
			next_r.status = r.status & ~wdata_i[ST_W-1:0];
		end
		if (ev_ccf) begin
			next_r.status[ST_CCF] = 1'b1;
		end
		if (cnt_ovf) begin
			next_r.status[ST_OVF] = 1'b1;
		end
		if (wr_mask) begin
			next_r.mask = wdata_i[ST_W-1:0];
		end

		// interrupt level follows the flags and mask being registered in this cycle
		next_r.irq = r.cfg[CFG_ECCF] && |(next_r.status & next_r.mask);

		// read data stands one cycle after the strobe
		next_r.rdata = RST_REG;
		if (rd_i) begin
			case (addr_i)
				ADDR_CFG:    next_r.rdata = r.cfg;
				ADDR_CMP_L:  next_r.rdata = r.cmp_l;
				ADDR_CMP_H:  next_r.rdata = r.cmp_h;
				ADDR_STATUS: next_r.rdata = {{(DATA_W-ST_W){1'b0}}, r.status};
				ADDR_MASK:   next_r.rdata = {{(DATA_W-ST_W){1'b0}}, r.mask};
				ADDR_PIN:    next_r.rdata = {1'b0, mode, 2'b00, r.oe_n, r.pin};
				default:     next_r.rdata = RST_REG;
			endcase
		end
	end

	// the single register stage
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			r        <= '0;
			r.cfg    <= RST_REG;
			r.cmp_l  <= RST_REG;
			r.cmp_h  <= RST_REG;
			r.status <= RST_ST;
			r.mask   <= RST_ST;
			r.oe_n   <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from flip-flops
	assign rdata_o           = r.rdata;
	assign module_pin_o      = r.pin;
	assign module_pin_oe_n_o = r.oe_n;
	assign irq_o             = r.irq;
endmodule

// file: hdl/ccpmd_pkg.sv
/*
 * shared constants and types of the capture/compare/pwm module:
 * register indices, configuration bit positions, reset values, modes.
 * assumes a single system clock and a plain register port.
 */
package ccpmd_pkg;

	// register port geometry
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned CNT_W  = 16;

	// register indices on the plain port
	localparam logic [ADDR_W-1:0] ADDR_CFG    = 3'h0; // module_config_reg
	localparam logic [ADDR_W-1:0] ADDR_CMP_L  = 3'h1; // compare_low_reg
	localparam logic [ADDR_W-1:0] ADDR_CMP_H  = 3'h2; // compare_high_reg
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h3; // sticky events, write one to clear
	localparam logic [ADDR_W-1:0] ADDR_MASK   = 3'h4; // interrupt mask
	localparam logic [ADDR_W-1:0] ADDR_PIN    = 3'h5; // pin and mode readback

	// module_config_reg bit positions
	localparam int unsigned CFG_OF   = 7; // output_flag_level
	localparam int unsigned CFG_COMPARATOR_ENABLE = 6; // comparator_enable
	localparam int unsigned CFG_RISE = 5; // rising_edge_select
	localparam int unsigned CFG_FALL = 4; // falling_edge_select
	localparam int unsigned CFG_MAT  = 3; // match_flag_enable
	localparam int unsigned CFG_TOG  = 2; // toggle_force_bit
	localparam int unsigned CFG_PWM  = 1; // pulse width bit
	localparam int unsigned CFG_ECCF = 0; // interrupt enable

	// status and mask bit positions
	localparam int unsigned ST_CCF = 0; // capture, match or pwm edge
	localparam int unsigned ST_OVF = 1; // main counter overflow
	localparam int unsigned ST_W   = 2;

	// reset values and wrap limits
	localparam logic [DATA_W-1:0] RST_REG  = 8'h00;
	localparam logic [ST_W-1:0]   RST_ST   = 2'h0;
	localparam logic [CNT_W-1:0]  RST_CNT  = 16'h0000;
	localparam logic [DATA_W-1:0] BYTE_MAX = 8'hff;
	localparam logic [CNT_W-1:0]  CNT_MAX  = 16'hffff;

	// operating modes
	typedef enum logic [2:0] {
		MODE_IDLE,
		MODE_CAPTURE,
		MODE_COMPARE,
		MODE_PWM8,
		MODE_PWM16,
		MODE_WINDOWED_PULSE_MODE
	} ccpmd_mode_t;

endpackage

// file: hdl/ccpmd_edge_if.sv
/*
 * carries the synchronised pin level and its edges from the
 * pin synchroniser to the mode logic. one clock domain.
 */
interface ccpmd_edge_if;
	logic level; // synchronised pin level
	logic rise;  // one-cycle pulse on a rising edge
	logic fall;  // one-cycle pulse on a falling edge

	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface

// file: hdl/ccpmd_pin_sync.sv
/*
 * two-flop synchroniser and edge detector for module_pin.
 * assumes the pin is asynchronous to sys_clk_i; rst_i synchronous.
 */
module ccpmd_pin_sync (
	input  wire logic    sys_clk_i,
	input  wire logic    rst_i,
	input  wire logic    pin_i,
	ccpmd_edge_if.src    edge_o
);
	import ccpmd_pkg::*;

	typedef struct packed {
		logic meta;  // first stage, read only by the second
		logic sync;  // second stage
		logic last;  // previous synchronised level
	} ccpmd_sync_t;

	ccpmd_sync_t r;
	ccpmd_sync_t next_r;

	// shift the pin through the stages
	always_comb begin
		next_r      = r;
		next_r.meta = pin_i;
		next_r.sync = r.meta;
		next_r.last = r.sync;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// edges are taken between the second and third stages only
	assign edge_o.level = r.sync;
	assign edge_o.rise  = r.sync & ~r.last;
	assign edge_o.fall  = ~r.sync & r.last;
endmodule

// file: tb/ccpmd_top_monitor.sv
/*
 * assertions on the ports of ccpmd_top, with a shadow of the config register.
 * assumes one clock and a synchronous active-high reset.
 */
module ccpmd_top_monitor (
	input wire logic                         sys_clk_i,
	input wire logic                         rst_i,
	input wire logic [ccpmd_pkg::ADDR_W-1:0] addr_i,
	input wire logic [ccpmd_pkg::DATA_W-1:0] wdata_i,
	input wire logic                         wr_i,
	input wire logic                         rd_i,
	input wire logic [ccpmd_pkg::DATA_W-1:0] rdata_o,
	input wire logic                         module_pin_o,
	input wire logic                         module_pin_oe_n_o,
	input wire logic                         irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import ccpmd_pkg::*;
	logic [7:0]  cfg;
	ccpmd_mode_t mode;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// shadow of the config register, with the enable set and cleared by hardware
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			cfg <= RST_REG;
		else if (wr_i && addr_i == ADDR_CFG)
			cfg <= wdata_i;
		else if (wr_i && addr_i == ADDR_CMP_H && cfg[5:4] == 2'h0 && !cfg[1]
			&& (cfg[7] || cfg[3] || cfg[2]))
			cfg[6] <= 1'b1;
		else if (wr_i && addr_i == ADDR_CMP_L && mode == MODE_COMPARE)
			cfg[6] <= 1'b0;
	end
	// mode decode from the shadow
	always_comb begin
		if (!cfg[6])
			mode = MODE_IDLE;
		else if (!cfg[1])
			mode = (cfg[5] || cfg[4]) ? MODE_CAPTURE : MODE_COMPARE;
		else if (cfg[5])
			mode = cfg[4] ? MODE_WINDOWED_PULSE_MODE : MODE_PWM16;
		else
			mode = cfg[4] ? MODE_IDLE : MODE_PWM8;
	end
	cfg_readback_a: assert property (rd_i && addr_i == ADDR_CFG |=> rdata_o == $past(cfg))
		else $error("config readback differs");
	mode_readback_a: assert property (rd_i && addr_i == ADDR_PIN |=> rdata_o[6:4] == $past(mode))
		else $error("mode readback differs");
	read_quiet_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside its cycle");
	unmapped_read_a: assert property (rd_i && addr_i > ADDR_PIN |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	pin_float_a: assert property (mode == MODE_IDLE || mode == MODE_CAPTURE |=> module_pin_oe_n_o)
		else $error("pin driven while idle or capturing");
	pin_drive_a: assert property (mode inside {MODE_COMPARE, MODE_PWM8, MODE_PWM16, MODE_WINDOWED_PULSE_MODE}
		|=> !module_pin_oe_n_o)
		else $error("pin not driven in output mode");
	idle_hold_a: assert property (mode == MODE_IDLE |=> $stable(module_pin_o))
		else $error("pin moved while idle");
	pwm_force_a: assert property ((mode == MODE_PWM8 || mode == MODE_PWM16) && cfg[2]
		|=> module_pin_o)
		else $error("forced pwm output not high");
	irq_gate_a: assert property (!cfg[0] |=> !irq_o)
		else $error("interrupt without enable");
	cover property (mode == MODE_CAPTURE);
	cover property (mode == MODE_WINDOWED_PULSE_MODE);
	cover property (irq_o);
endmodule

bind ccpmd_top ccpmd_top_monitor ccpmd_top_monitor_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.module_pin_o(module_pin_o), .module_pin_oe_n_o(module_pin_oe_n_o), .irq_o(irq_o));

// file: tb/ccpmd_pin_model.sv
/*
 * outside source and load on module_pin.
 * assumes oe_n low means the block drives the pin.
 */
module ccpmd_pin_model (
	input  wire logic drv_i,
	input  wire logic oe_n_i,
	input  wire logic ext_i,
	output wire logic pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// block wins while driving, else the outside source
	assign pin_o = oe_n_i ? ext_i : drv_i;
endmodule

// file: tb/ccpmd_top_test.sv
/*
 * self-checking bench of ccpmd_top: register tasks, capture, compare, pwm.
 * assumes the pin model and the bound checker.
 */
module ccpmd_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ccpmd_pkg::*;
	logic              sys_clk_i = 1'b0;
	logic              rst_i = 1'b1;
	logic [ADDR_W-1:0] addr = 3'h0;
	logic [DATA_W-1:0] wdata = 8'h00;
	logic [DATA_W-1:0] rdata;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic              ext = 1'b0;
	logic              p;
	logic              pin, pin_o, oe_n, irq;
	logic [CNT_W-1:0]  cnt = 16'h0000;
	logic [CNT_W-1:0]  cap = 16'h0000;
	logic [7:0]        sel [3] = '{8'h61, 8'h51, 8'h71};
	logic [7:0]        cmpc [6] = '{8'hc8, 8'h4c, 8'h48, 8'hc8, 8'hcc, 8'h0c};
	int                fails = 0;
	int                checked = 0;
	int                cyc = 0;

	ccpmd_top ccpmd_top_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .main_count_i(cnt),
		.module_pin_i(pin), .module_pin_o(pin_o), .module_pin_oe_n_o(oe_n), .irq_o(irq));
	ccpmd_pin_model ccpmd_pin_model_inst (.drv_i(pin_o), .oe_n_i(oe_n), .ext_i(ext), .pin_o(pin));

	always #2.5 sys_clk_i = ~sys_clk_i;
	// cut a hang short
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails = fails + 1;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr8(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk_i);
		wr <= 1'b0;
	endtask
	task automatic rd8(input logic [2:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk_i);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask
	// hold a count and look at the pin once it has followed
	task automatic pin_at(input logic [15:0] v, input logic e);
		@(posedge sys_clk_i);
		cnt <= v;
		repeat (2) @(posedge sys_clk_i);
		#1 chk("pin", e, pin_o);
	endtask
	// move the outside pin under a frozen count, then read the capture
	task automatic edge_to(input logic lvl, input logic take, input logic [15:0] v);
		@(posedge sys_clk_i);
		cnt <= v;
		ext <= lvl;
		repeat (6) @(posedge sys_clk_i);
		if (take)
			cap = v;
		rd8(ADDR_CMP_L, cap[7:0]);
		rd8(ADDR_CMP_H, cap[15:8]);
	endtask
	task automatic settle;
		repeat (2) @(posedge sys_clk_i);
		#1;
	endtask

	initial begin
		repeat (3) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		// unmapped writes, then reset values of every index
		wr8(3'h6, 8'hff);
		wr8(3'h7, 8'hff);
		for (int a = 0; a < 8; a++)
			rd8(3'(a), (a == 5) ? 8'h02 : 8'h00);
		// capture on each edge choice, interrupt masked at first
		foreach (sel[i]) begin
			wr8(ADDR_CFG, sel[i]);
			edge_to(1'b1, sel[i][5], 16'h1100 + 16'(i));
			edge_to(1'b0, sel[i][4], 16'h2200 + 16'(i));
		end
		rd8(ADDR_STATUS, 8'h01);
		chk("irq", 1'b0, irq);
		wr8(ADDR_MASK, 8'h01);
		settle();
		chk("irq", 1'b1, irq);
		wr8(ADDR_STATUS, 8'h01);
		settle();
		chk("irq", 1'b0, irq);
		// a setup without OF, MAT or TOG refuses the hardware enable; compare writes drop and restore it
		wr8(ADDR_CFG, 8'h00);
		wr8(ADDR_CMP_L, 8'h10);
		wr8(ADDR_CMP_H, 8'h00);
		rd8(ADDR_CFG, 8'h00);
		wr8(ADDR_CFG, 8'h4c);
		wr8(ADDR_CMP_L, 8'h10);
		rd8(ADDR_CFG, 8'h0c);
		rd8(ADDR_PIN, 8'h02);
		wr8(ADDR_CMP_H, 8'h00);
		rd8(ADDR_CFG, 8'h4c);
		// every pin action on a one-cycle match, last one disabled
		foreach (cmpc[i]) begin
			wr8(ADDR_CFG, cmpc[i]);
			#1 p = pin_o;
			@(posedge sys_clk_i);
			cnt <= 16'h0010;
			@(posedge sys_clk_i);
			cnt <= 16'h0011;
			@(posedge sys_clk_i);
			#1 chk("pin", cmpc[i][6] ? (cmpc[i][7] ? cmpc[i][2] : cmpc[i][2] ^ p) : p, pin_o);
		end
		// pwm8 on the low byte, new value only after a low-byte wrap
		wr8(ADDR_CFG, 8'h00);
		wr8(ADDR_CMP_L, 8'h80);
		wr8(ADDR_CFG, 8'h42);
		pin_at(16'h3780, 1'b0);
		pin_at(16'h3781, 1'b1);
		pin_at(16'h3700, 1'b0);
		pin_at(16'h37ff, 1'b1);
		wr8(ADDR_CMP_L, 8'h20);
		pin_at(16'h3750, 1'b0);
		pin_at(16'h37ff, 1'b1);
		pin_at(16'h3800, 1'b0);
		pin_at(16'h3850, 1'b1);
		wr8(ADDR_CFG, 8'h46);
		pin_at(16'h3810, 1'b1);
		// pwm16 on the whole count
		wr8(ADDR_CFG, 8'h62);
		pin_at(16'h0020, 1'b0);
		pin_at(16'h0120, 1'b1);
		wr8(ADDR_CFG, 8'h66);
		pin_at(16'h0000, 1'b1);
		// windowed pwm, then inverted
		wr8(ADDR_CFG, 8'h00);
		wr8(ADDR_CMP_L, 8'h40);
		wr8(ADDR_CMP_H, 8'hc0);
		wr8(ADDR_CFG, 8'h72);
		pin_at(16'h0040, 1'b0);
		pin_at(16'h0041, 1'b1);
		pin_at(16'h00c0, 1'b1);
		pin_at(16'h00c1, 1'b0);
		wr8(ADDR_CFG, 8'h76);
		pin_at(16'h0041, 1'b0);
		pin_at(16'h00c1, 1'b1);
		rd8(ADDR_PIN, 8'h51);
		// a full counter wrap raises the overflow flag alone
		wr8(ADDR_STATUS, 8'h03);
		pin_at(16'hffff, 1'b1);
		pin_at(16'h0000, 1'b1);
		rd8(ADDR_STATUS, 8'h02);
		tally_and_finish();
	end
endmodule
